/* File: hw/pcsia_top.sv */
`timescale 1ns/1ps
module pcsia_top #(
	parameter logic [pcsia_pkg::PC_W-1:0] IRQ_VECTOR = 13'h0008
) (
	// clock and reset
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// instruction decoder
	input  wire logic                          core_step,
	input  wire logic                          core_call,
	input  wire logic                          core_goto,
	input  wire logic                          core_return,
	input  wire logic                          core_return_with_literal,
	input  wire logic                          core_return_from_interrupt,
	input  wire logic                          core_irq,
	input  wire logic                          core_pc_low_byte_wr,
	input  wire logic [pcsia_pkg::LOW_W-1:0]   core_pc_low_byte_data,
	input  wire logic [pcsia_pkg::PAGE_W-1:0]  core_target,
	// program memory
	output logic [pcsia_pkg::PC_W-1:0]         pc_out,
	output logic [pcsia_pkg::PC_W-1:0]         fetch_addr,
	// register file
	output logic [pcsia_pkg::EA_W-1:0]         file_addr,
	output logic                               file_rd,
	output logic                               file_wr,
	output logic [pcsia_pkg::LOW_W-1:0]        file_wdata,
	input  wire logic [pcsia_pkg::LOW_W-1:0]   file_rdata
);

	logic [pcsia_pkg::PC_W-1:0]    pc_reg;
	logic [pcsia_pkg::PC_W-1:0]    pc_next;
	logic [pcsia_pkg::PC_W-1:0]    fetch_reg;
	logic [pcsia_pkg::LATCH_W-1:0] latch_reg;
	logic [pcsia_pkg::FP_W-1:0]    fp_reg;
	logic                          bank_reg;
	logic [pcsia_pkg::PC_W-1:0]    stack_mem [pcsia_pkg::STACK_DEPTH];
	logic [pcsia_pkg::SP_W-1:0]    sp_reg;
	logic                          push;
	logic                          pop;
	logic [pcsia_pkg::PC_W-1:0]    push_val;
	logic                          ret_any;

	pcsia_pkg::pcsia_bus_state_t   state_reg;
	logic                          wr_phase_reg;
	logic [pcsia_pkg::OFS_W-1:0]   ofs_reg;
	logic                          hready_reg;
	logic [31:0]                   hrdata_reg;
	logic                          file_rd_reg;
	logic                          file_wr_reg;
	logic [pcsia_pkg::EA_W-1:0]    file_addr_reg;
	logic [pcsia_pkg::LOW_W-1:0]   file_wdata_reg;
	logic                          addr_take;
	logic                          bus_wr;
	logic                          bus_wr_low;
	logic                          fp_self;

	function automatic logic [pcsia_pkg::EA_W-1:0] eff_addr(input logic bank, input logic [pcsia_pkg::FP_W-1:0] fp);
		eff_addr = {bank, fp};
	endfunction

	assign ret_any    = core_return | core_return_with_literal | core_return_from_interrupt;
	assign addr_take  = hsel & hready & htrans[pcsia_pkg::HTRANS_VALID];
	assign bus_wr     = wr_phase_reg;
	assign bus_wr_low = bus_wr && (ofs_reg == pcsia_pkg::OFS_PC_LOW);
	assign fp_self    = (fp_reg == pcsia_pkg::SELF_PTR);

	// interrupt vectoring outranks everything so an interrupt is never dropped
	always_comb begin
		pc_next  = pc_reg;
		push     = 1'b0;
		pop      = 1'b0;
		push_val = pc_reg;
		if (core_irq) begin
			pc_next = IRQ_VECTOR;
			push    = 1'b1;
		end else if (bus_wr_low) begin
			pc_next = {latch_reg, hwdata[pcsia_pkg::LOW_W-1:0]};
		end else if (core_pc_low_byte_wr) begin
			pc_next = {latch_reg, core_pc_low_byte_data};
		end else if (core_call) begin
			pc_next  = {latch_reg[pcsia_pkg::PAGE_HI:pcsia_pkg::PAGE_LO], core_target};
			push     = 1'b1;
			push_val = pc_reg + pcsia_pkg::PC_ONE;
		end else if (core_goto) begin
			pc_next = {latch_reg[pcsia_pkg::PAGE_HI:pcsia_pkg::PAGE_LO], core_target};
		end else if (ret_any) begin
			pc_next = stack_mem[sp_reg - pcsia_pkg::SP_ONE];
			pop     = 1'b1;
		end else if (core_step) begin
			pc_next = pc_reg + pcsia_pkg::PC_ONE;
		end
	end

	// whole counter cleared on reset, high part included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_reg    <= pcsia_pkg::PC_RESET;
			fetch_reg <= pcsia_pkg::PC_RESET;
		end else begin
			pc_reg    <= pc_next;
			fetch_reg <= pc_next & pcsia_pkg::FETCH_MASK;
		end
	end

	// no full or empty tracking: wraps in both directions, nothing flagged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_reg <= '0;
		end else if (push) begin
			sp_reg <= sp_reg + pcsia_pkg::SP_ONE;
		end else if (pop) begin
			sp_reg <= sp_reg - pcsia_pkg::SP_ONE;
		end
	end

	// entries carry no reset; contents before the first push are undefined
	always_ff @(posedge hclk) begin
		if (push) begin
			stack_mem[sp_reg] <= push_val;
		end
	end

	// upper latch only moves on a bus write, never on push or pop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_reg <= '0;
			fp_reg    <= '0;
			bank_reg  <= 1'b0;
		end else if (bus_wr) begin
			unique case (ofs_reg)
				pcsia_pkg::OFS_LATCH:    latch_reg <= hwdata[pcsia_pkg::LATCH_W-1:0];
				pcsia_pkg::OFS_FILE_PTR: fp_reg    <= hwdata[pcsia_pkg::FP_W-1:0];
				pcsia_pkg::OFS_STATUS:   bank_reg  <= hwdata[pcsia_pkg::BANK_BIT];
				default:                 ;
			endcase
		end
	end

	// data phase tracking: writes take no wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase_reg <= 1'b0;
			ofs_reg      <= '0;
		end else begin
			wr_phase_reg <= addr_take & hwrite;
			if (addr_take) begin
				ofs_reg <= haddr[pcsia_pkg::OFS_W-1:0];
			end
		end
	end

	// register reads wait one cycle, indirect file reads three, so a write just before is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg   <= pcsia_pkg::ST_IDLE;
			hready_reg  <= 1'b1;
			hrdata_reg  <= pcsia_pkg::WORD_ZERO;
			file_rd_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				pcsia_pkg::ST_IDLE: begin
					if (addr_take && !hwrite) begin
						state_reg  <= pcsia_pkg::ST_RD;
						hready_reg <= 1'b0;
					end
				end
				pcsia_pkg::ST_RD: begin
					hrdata_reg <= pcsia_pkg::WORD_ZERO;
					unique case (ofs_reg)
						pcsia_pkg::OFS_PC_LOW:   hrdata_reg[pcsia_pkg::LOW_W-1:0] <= pc_reg[pcsia_pkg::LOW_W-1:0];
						pcsia_pkg::OFS_LATCH:    hrdata_reg[pcsia_pkg::LATCH_W-1:0] <= latch_reg;
						pcsia_pkg::OFS_FILE_PTR: hrdata_reg[pcsia_pkg::FP_W-1:0] <= fp_reg;
						pcsia_pkg::OFS_STATUS:   hrdata_reg[pcsia_pkg::BANK_BIT] <= bank_reg;
						default:                 ;
					endcase
					if (ofs_reg == pcsia_pkg::OFS_INDIRECT && !fp_self) begin
						state_reg   <= pcsia_pkg::ST_FWAIT;
						file_rd_reg <= 1'b1;
					end else begin
						state_reg  <= pcsia_pkg::ST_IDLE;
						hready_reg <= 1'b1;
					end
				end
				pcsia_pkg::ST_FWAIT: begin
					file_rd_reg <= 1'b0;
					state_reg   <= pcsia_pkg::ST_FCAP;
				end
				pcsia_pkg::ST_FCAP: begin
					hrdata_reg <= {24'h00_0000, file_rdata};
					hready_reg <= 1'b1;
					state_reg  <= pcsia_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// register file port: reads issued by the read sequencer, writes from the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			file_wr_reg    <= 1'b0;
			file_addr_reg  <= '0;
			file_wdata_reg <= '0;
		end else begin
			file_wr_reg <= 1'b0;
			if (bus_wr && ofs_reg == pcsia_pkg::OFS_INDIRECT && !fp_self) begin
				file_wr_reg    <= 1'b1;
				file_addr_reg  <= eff_addr(bank_reg, fp_reg);
				file_wdata_reg <= hwdata[pcsia_pkg::LOW_W-1:0];
			end else if (state_reg == pcsia_pkg::ST_RD && ofs_reg == pcsia_pkg::OFS_INDIRECT && !fp_self) begin
				file_addr_reg <= eff_addr(bank_reg, fp_reg);
			end
		end
	end

	assign hreadyout  = hready_reg;
	assign hresp      = pcsia_pkg::HRESP_OKAY;
	assign hrdata     = hrdata_reg;
	assign pc_out     = pc_reg;
	assign fetch_addr = fetch_reg;
	assign file_addr  = file_addr_reg;
	assign file_rd    = file_rd_reg;
	assign file_wr    = file_wr_reg;
	assign file_wdata = file_wdata_reg;

	a_low_load: assert property (@(posedge hclk) disable iff (!hresetn)
		(bus_wr_low && !core_irq) |=> pc_reg == {$past(latch_reg), $past(hwdata[7:0])})
		else $error("low byte write did not load counter from latch");

	a_goto_page: assert property (@(posedge hclk) disable iff (!hresetn)
		(core_goto && !core_call && !core_irq && !bus_wr_low && !core_pc_low_byte_wr)
		|=> pc_reg == {$past(latch_reg[4:3]), $past(core_target)})
		else $error("goto target not formed from page bits and instruction");

	// one quiet cycle between call and return, as a decoder issuing two-cycle branches gives
	a_call_return: assert property (@(posedge hclk) disable iff (!hresetn)
		(core_call && !core_irq && !bus_wr_low && !core_pc_low_byte_wr)
		##1 !(core_irq || bus_wr_low || core_pc_low_byte_wr || core_call || core_goto || ret_any || core_step)
		##1 (ret_any && !core_irq && !bus_wr_low && !core_pc_low_byte_wr && !core_call && !core_goto)
		|=> pc_reg == $past(pc_reg, 3) + 13'h0001)
		else $error("return did not resume after the call");

	a_irq_push: assert property (@(posedge hclk) disable iff (!hresetn)
		core_irq |=> pc_reg == IRQ_VECTOR && stack_mem[$past(sp_reg)] == $past(pc_reg))
		else $error("interrupt did not push counter and vector");

	a_latch_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		((push || pop) && !(bus_wr && ofs_reg == pcsia_pkg::OFS_LATCH)) |=> $stable(latch_reg))
		else $error("upper latch changed on push or pop");

	a_stack_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(push && sp_reg == 3'h7) |=> sp_reg == 3'h0)
		else $error("stack pointer did not wrap on push");

	a_pop_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(pop && sp_reg == 3'h0) |=> sp_reg == 3'h7)
		else $error("stack pointer did not wrap on pop");

	a_fetch_bit: assert property (@(posedge hclk) disable iff (!hresetn)
		fetch_addr[12] == 1'b0 && fetch_addr[11:0] == pc_reg[11:0])
		else $error("fetch address uses latch bit four");

	a_self_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == pcsia_pkg::ST_RD && ofs_reg == pcsia_pkg::OFS_INDIRECT && fp_self)
		|=> hready_reg && hrdata_reg == 32'h0000_0000 && !file_rd_reg)
		else $error("self indirect read not zero");

	a_self_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(bus_wr && ofs_reg == pcsia_pkg::OFS_INDIRECT && fp_self) |=> !file_wr_reg)
		else $error("self indirect write reached the file");

	a_ind_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(file_rd_reg) |-> file_addr_reg == {$past(bank_reg), $past(fp_reg)} ##2 hready_reg)
		else $error("indirect read address or timing wrong");

	a_reset_clear: assert property (@(posedge hclk)
		$rose(hresetn) |-> pc_reg == pcsia_pkg::PC_RESET && fetch_reg == pcsia_pkg::PC_RESET)
		else $error("counter not cleared by reset");

	a_step_inc: assert property (@(posedge hclk) disable iff (!hresetn)
		(core_step && !core_irq && !bus_wr_low && !core_pc_low_byte_wr && !core_call && !core_goto && !ret_any)
		|=> pc_reg == $past(pc_reg) + 13'h0001)
		else $error("step did not advance the counter");

	a_call_push: assert property (@(posedge hclk) disable iff (!hresetn)
		(core_call && !core_irq && !bus_wr_low && !core_pc_low_byte_wr)
		|=> stack_mem[$past(sp_reg)] == $past(pc_reg) + 13'h0001 && sp_reg == $past(sp_reg) + 3'h1)
		else $error("call did not push the return address");

	a_ret_pop: assert property (@(posedge hclk) disable iff (!hresetn)
		(ret_any && !core_irq && !bus_wr_low && !core_pc_low_byte_wr && !core_call && !core_goto)
		|=> pc_reg == $past(stack_mem[sp_reg - 3'h1]) && sp_reg == $past(sp_reg) - 3'h1)
		else $error("return did not pop the top entry");

	// the high part must never leak onto the bus
	a_low_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == pcsia_pkg::ST_RD && ofs_reg == pcsia_pkg::OFS_PC_LOW)
		|=> hrdata_reg == {24'h00_0000, $past(pc_reg[7:0])})
		else $error("counter read showed more than the low byte");

	a_latch_load: assert property (@(posedge hclk) disable iff (!hresetn)
		(bus_wr && ofs_reg == pcsia_pkg::OFS_LATCH) |=> latch_reg == $past(hwdata[4:0]))
		else $error("upper latch write lost");

	a_ind_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(bus_wr && ofs_reg == pcsia_pkg::OFS_INDIRECT && !fp_self)
		|=> file_wr_reg && file_addr_reg == {$past(bank_reg), $past(fp_reg)}
		&& file_wdata_reg == $past(hwdata[7:0]))
		else $error("indirect write not passed to the file");

	a_rd_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		file_rd_reg |=> !file_rd_reg)
		else $error("file read strobe longer than one cycle");

	a_sp_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!(push || pop) |=> $stable(sp_reg))
		else $error("stack pointer moved without push or pop");

endmodule // pcsia_top

/* File: hw/pcsia_pkg.sv */
package pcsia_pkg;

	// widths
	localparam int PC_W        = 13;
	localparam int LOW_W       = 8;
	localparam int LATCH_W     = 5;
	localparam int PAGE_W      = 11;
	localparam int FP_W        = 8;
	localparam int EA_W        = 9;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W        = 3;
	localparam int OFS_W       = 5;

	// register offsets inside the slave window, byte addresses
	localparam logic [OFS_W-1:0] OFS_PC_LOW   = 5'h00;
	localparam logic [OFS_W-1:0] OFS_LATCH    = 5'h04;
	localparam logic [OFS_W-1:0] OFS_FILE_PTR = 5'h08;
	localparam logic [OFS_W-1:0] OFS_STATUS   = 5'h0c;
	localparam logic [OFS_W-1:0] OFS_INDIRECT = 5'h10;

	// field positions
	localparam int BANK_BIT     = 7;
	localparam int PAGE_HI      = 4;
	localparam int PAGE_LO      = 3;
	localparam int UNUSED_PC    = 12;
	localparam int HTRANS_VALID = 1;

	// values
	localparam logic [FP_W-1:0]  SELF_PTR   = 8'h00;
	localparam logic [31:0]      WORD_ZERO  = 32'h0000_0000;
	localparam logic             HRESP_OKAY = 1'b0;
	localparam logic [PC_W-1:0]  PC_ONE     = 13'h0001;
	localparam logic [PC_W-1:0]  PC_RESET   = 13'h0000;
	localparam logic [PC_W-1:0]  FETCH_MASK = 13'h0fff;
	localparam logic [SP_W-1:0]  SP_ONE     = 3'h1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD,
		ST_FWAIT,
		ST_FCAP
	} pcsia_bus_state_t;

endpackage

/* File: sim/pcsia_regfile_model.sv */
`timescale 1ns/1ps
module pcsia_regfile_model (
	// clock
	input  wire logic       hclk,
	// register file side
	input  wire logic [8:0] file_addr,
	input  wire logic       file_rd,
	input  wire logic       file_wr,
	input  wire logic [7:0] file_wdata,
	output logic      [7:0] file_rdata
);
	logic [7:0] mem [0:511];

	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
		file_rdata = 8'h00;
	end

	// data toggles outside the read slot so a sample one cycle late never matches
	always @(posedge hclk) begin
		if (file_rd) begin
			file_rdata <= mem[file_addr];
		end else begin
			file_rdata <= ~file_rdata;
		end
		if (file_wr) begin
			mem[file_addr] <= file_wdata;
		end
	end
endmodule // pcsia_regfile_model

/* File: sim/pcsia_top_tb.sv */
`timescale 1ns/1ps
module pcsia_top_tb;
	logic        hclk;
	logic        hresetn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic [7:0]  ops;
	logic [7:0]  low_data;
	logic        hresp;
	logic [10:0] target;
	logic [12:0] pc_out;
	logic [12:0] fetch_addr;
	logic [8:0]  file_addr;
	logic        file_rd;
	logic        file_wr;
	logic [7:0]  file_wdata;
	logic [7:0]  file_rdata;
	logic [31:0] rd;
	logic [12:0] stk [0:7];
	logic [2:0]  sp;
	logic [12:0] exp_pc;
	logic [4:0]  lat;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	pcsia_top pcsia_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .core_step(ops[7]), .core_call(ops[6]), .core_goto(ops[5]),
		.core_return(ops[4]), .core_return_with_literal(ops[3]), .core_return_from_interrupt(ops[2]),
		.core_irq(ops[1]), .core_pc_low_byte_wr(ops[0]), .core_pc_low_byte_data(low_data),
		.core_target(target), .pc_out(pc_out),
		.fetch_addr(fetch_addr), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
		.file_wdata(file_wdata), .file_rdata(file_rdata));

	pcsia_regfile_model pcsia_regfile_model_i (.hclk(hclk), .file_addr(file_addr), .file_rd(file_rd),
		.file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata));

	task print_verdict;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// single ahb transfer; expected pc and latch follow the writes
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'(pcsia_pkg::HRESP_OKAY));
		if (wr && a == pcsia_pkg::OFS_LATCH) lat = d[4:0];
		if (wr && a == pcsia_pkg::OFS_PC_LOW) exp_pc = {lat, d[7:0]};
		#1;
	endtask

	// one decoder pulse; bit 7 step .. bit 0 low-byte write
	task core(input int b, input logic [10:0] t, input logic [7:0] d);
		@(posedge hclk);
		ops <= 8'(1) << b;
		target <= t;
		low_data <= d;
		@(posedge hclk);
		ops <= 8'h00;
		case (b)
			7: exp_pc = exp_pc + 13'h1;
			6: begin
				stk[sp] = exp_pc + 13'h1;
				sp = sp + 3'h1;
				exp_pc = {lat[4:3], t};
			end
			5: exp_pc = {lat[4:3], t};
			4, 3, 2: begin
				sp = sp - 3'h1;
				exp_pc = stk[sp];
			end
			1: begin
				stk[sp] = exp_pc;
				sp = sp + 3'h1;
				exp_pc = 13'h0008;
			end
			default: exp_pc = {lat, d};
		endcase
		#1;
		chk(32'(pc_out), 32'(exp_pc));
		chk(32'(fetch_addr), 32'(exp_pc & pcsia_pkg::FETCH_MASK));
	endtask

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			print_verdict();
		end
	end

	initial begin
		hresetn = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ops = 8'h00;
		target = 11'h000;
		low_data = 8'h00;
		sp = 3'h0;
		exp_pc = 13'h0000;
		lat = 5'h00;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk(32'(pc_out), 32'h0);
		bus(1'b1, pcsia_pkg::OFS_LATCH, 32'h1f);
		bus(1'b1, pcsia_pkg::OFS_PC_LOW, 32'h34);
		chk(32'(pc_out), 32'h1f34);
		chk(32'(fetch_addr), 32'h0f34);
		bus(1'b0, pcsia_pkg::OFS_PC_LOW, 32'h0);
		chk(rd, 32'h34);
		bus(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0);
		core(6, 11'h123, 8'h00);
		bus(1'b0, pcsia_pkg::OFS_LATCH, 32'h0);
		chk(rd, 32'h1f);
		core(4, 11'h000, 8'h00);
		core(7, 11'h000, 8'h00);
		core(0, 11'h000, 8'h77);
		core(5, 11'h7ff, 8'h00);
		bus(1'b1, pcsia_pkg::OFS_LATCH, 32'h08);
		for (int i = 0; i < 10; i++) begin
			core(6, 11'(i * 17), 8'h00);
		end
		for (int i = 0; i < 9; i++) begin
			core(4 - (i % 3), 11'h000, 8'h00);
		end
		core(1, 11'h000, 8'h00);
		core(2, 11'h000, 8'h00);
		bus(1'b1, pcsia_pkg::OFS_FILE_PTR, 32'h20);
		bus(1'b1, pcsia_pkg::OFS_STATUS, 32'h80);
		bus(1'b0, pcsia_pkg::OFS_INDIRECT, 32'h0);
		chk(rd, 32'h7a);
		chk(32'(file_addr), 32'h120);
		bus(1'b1, pcsia_pkg::OFS_INDIRECT, 32'ha5);
		bus(1'b0, pcsia_pkg::OFS_INDIRECT, 32'h0);
		chk(rd, 32'ha5);
		bus(1'b1, pcsia_pkg::OFS_FILE_PTR, 32'h00);
		bus(1'b0, pcsia_pkg::OFS_INDIRECT, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, pcsia_pkg::OFS_INDIRECT, 32'h3c);
		repeat (2) @(posedge hclk);
		chk(32'(pcsia_regfile_model_i.mem[256]), 32'h5a);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk(32'(pc_out), 32'h0);
		chk(32'(fetch_addr), 32'h0);
		print_verdict();
	end
endmodule // pcsia_top_tb
